// *** rtl/pmsr_responder.sv ***
// processor-side responder for management services and register reads
// assumes a link layer that decodes frames into service and command
// requests and accepts answer bytes one per cycle
`timescale 1ns/10ps
`default_nettype none
module pmsr_responder (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // decoded service request
  input wire pmsr_pkg::pmsr_svc_req_t svc_req_in,
  output pmsr_pkg::pmsr_svc_rsp_t svc_rsp_out,
  // register read command header and payload
  input wire logic msr_cmd_valid_in,
  input wire logic [7:0] msr_write_len_in,
  input wire logic [7:0] msr_read_len_in,
  input wire logic [7:0] msr_cmd_in,
  input wire logic [7:0] msr_thread_in,
  input wire logic [15:0] msr_addr_in,
  // core register lookup, same-clock logic
  output pmsr_pkg::pmsr_msr_req_t msr_lookup_out,
  input wire pmsr_pkg::pmsr_msr_rsp_t msr_lookup_in,
  input wire logic [15:0] thread_avail_in,
  // answer byte stream
  input wire logic rsp_ready_in,
  output logic rsp_byte_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic rsp_last_out,
  output logic rsp_abort_out,
  output logic rsp_busy_out,
  // package activity, asynchronous pins
  input wire logic pkg_clamped_in,
  input wire logic core_retiring_in,
  input wire logic internal_error_flag_in,
  input wire logic [3:0] first_failing_core_in,
  input wire logic [7:0] agent_enable_in,
  // thermal and table sources, same clock
  input wire logic [15:0] margin_in,
  input wire logic [31:0] table_data_in,
  output logic [10:0] table_sel_out,
  // performance control
  input wire logic [7:0] os_pstate_in,
  input wire logic [7:0] limit_pstate_in,
  input wire logic [3:0] energy_perf_bias_in,
  input wire logic [7:0] turbo_max_in,
  output logic [7:0] granted_pstate_out,
  output logic turbo_enable_out,
  output logic [7:0] turbo_notify_threshold_out
);
  import pmsr_pkg::*;

  // ----------------------------------------------------------------
  // synchronisers for pin inputs
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [3:0] core_a;
  logic [3:0] core_b;
  logic [7:0] agent_a;
  logic [7:0] agent_b;

  // first stage read only by second stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      core_a <= 4'h0;
      core_b <= 4'h0;
      agent_a <= 8'h00;
      agent_b <= 8'h00;
    end else begin
      sync_a <= {internal_error_flag_in, core_retiring_in, pkg_clamped_in};
      sync_b <= sync_a;
      core_a <= first_failing_core_in;
      core_b <= core_a;
      agent_a <= agent_enable_in;
      agent_b <= agent_a;
    end
  end

  wire logic clamped_s = sync_b[0];
  wire logic retiring_s = sync_b[1];
  wire logic err_s = sync_b[2];

  // ----------------------------------------------------------------
  // activity counters
  // ----------------------------------------------------------------
  logic [31:0] clamp_time;
  logic [31:0] productive;

  // both wrap on overflow; host detects wrap by frequent sampling
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clamp_time <= COUNT_RESET;
      productive <= COUNT_RESET;
    end else begin
      if (clamped_s)
        clamp_time <= clamp_time + 32'h1;
      if (retiring_s)
        productive <= productive + 32'h1; // idle cycles not counted
    end
  end

  // ----------------------------------------------------------------
  // first failing core capture with settle delay
  // ----------------------------------------------------------------
  logic err_seen;
  logic core_valid;
  logic [3:0] first_failing_core;
  logic [16:0] settle;
  wire logic settle_done = (settle == 17'(CORE_VALID_CYC - 1));

  // error latched at once; id word and valid taken after the settle time
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      err_seen <= 1'b0;
      core_valid <= 1'b0;
      first_failing_core <= 4'h0;
      settle <= 17'h0;
    end else if (err_s && !err_seen) begin
      err_seen <= 1'b1;
    end else if (err_seen && !core_valid) begin
      settle <= settle + 17'h1;
      // id word sampled long after it settled, never while bits change
      if (settle_done) begin
        core_valid <= 1'b1;
        first_failing_core <= core_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // turbo notify threshold and performance decision
  // ----------------------------------------------------------------
  logic [7:0] notify_thr;
  wire logic wr_notify = svc_req_in.valid &&
                         (svc_req_in.svc == PMSR_SVC_NOTIFY_WR);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      notify_thr <= NOTIFY_RESET;
    else if (wr_notify)
      notify_thr <= svc_req_in.wdata[NOTIFY_MSB:0];
  end

  // above threshold: turbo scaled by bias; otherwise grant capped by limit
  // no thermal monitor or clamp mode input enters this decision
  wire logic above_thr = (os_pstate_in > notify_thr);
  wire logic [7:0] bias_span = turbo_max_in - limit_pstate_in;
  wire logic [11:0] bias_prod = {4'h0, bias_span} *
                                {8'h00, 4'hf - energy_perf_bias_in};
  wire logic [7:0] turbo_pick = limit_pstate_in + bias_prod[11:4];
  wire logic [7:0] capped_req = (os_pstate_in > limit_pstate_in) ?
                                limit_pstate_in : os_pstate_in;
  wire logic [7:0] next_grant = above_thr ? turbo_pick : capped_req;

  // registered so the outputs come from flip-flops
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      granted_pstate_out <= 8'h00;
      turbo_enable_out <= 1'b0;
      turbo_notify_threshold_out <= NOTIFY_RESET;
    end else begin
      granted_pstate_out <= next_grant;
      turbo_enable_out <= above_thr; // no turbo at or below
      turbo_notify_threshold_out <= notify_thr;
    end
  end

  // ----------------------------------------------------------------
  // service answers
  // ----------------------------------------------------------------
  wire logic [15:0] p = svc_req_in.param;
  wire logic table_mode = p[TBL_MODE_BIT];
  wire logic [1:0] tbl_bank = p[TBL_BANK_LSB +: 2];
  wire logic [4:0] tbl_entry = p[TBL_ENTRY_LSB +: 5];
  wire logic [3:0] tbl_agent = p[TBL_AGENT_LSB +: 4];
  // agent index above 7 is host misuse; it reads as disabled
  wire logic agent_on = (tbl_agent < 4'(NUM_AGENTS)) &&
                        agent_b[tbl_agent[2:0]];
  // failing-core mode ignores bank, entry and agent
  wire logic [31:0] core_word = {23'h0, core_valid, 4'h0, first_failing_core};
  wire logic [31:0] table_word = agent_on ? table_data_in : 32'h0;
  // margin passes through at any die temperature, upper half zero
  wire logic [31:0] margin_word = {16'h0, margin_in};

  logic [31:0] next_svc_data;
  always_comb begin
    unique case (svc_req_in.svc)
      PMSR_SVC_PERF_STATUS: next_svc_data = clamp_time;
      PMSR_SVC_INDICATOR: next_svc_data = productive;
      PMSR_SVC_NOTIFY_WR: next_svc_data = 32'h0;
      PMSR_SVC_NOTIFY_RD: next_svc_data = {24'h0, notify_thr};
      PMSR_SVC_TABLE_RD:
        next_svc_data = table_mode ? core_word : table_word;
      PMSR_SVC_MARGIN_RD: next_svc_data = margin_word;
      default: next_svc_data = 32'h0;
    endcase
  end

  // unknown service codes answer as illegal requests
  wire logic svc_known = (svc_req_in.svc <= PMSR_SVC_MARGIN_RD);

  // one-cycle answer for every service, code leading
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      svc_rsp_out <= '0;
      table_sel_out <= 11'h0;
    end else begin
      svc_rsp_out.valid <= svc_req_in.valid;
      svc_rsp_out.cc <= svc_known ? CC_PASS : CC_ILLEGAL;
      svc_rsp_out.data <= svc_known ? next_svc_data : 32'h0;
      table_sel_out <= {tbl_agent, tbl_entry, tbl_bank};
    end
  end

  // ----------------------------------------------------------------
  // register read command
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMSR_MSR_IDLE,
    PMSR_MSR_LOOKUP,
    PMSR_MSR_SEND
  } pmsr_msr_state_t;

  pmsr_msr_state_t state;
  logic [7:0] msr_cc;
  logic [63:0] msr_data;
  logic msr_abort;
  logic ser_load;

  // framing check and thread checks on the header
  wire logic frame_ok = (msr_write_len_in == MSR_WRITE_LEN) &&
                        (msr_read_len_in == MSR_READ_LEN) &&
                        (msr_cmd_in == MSR_CMD_CODE);
  wire logic thread_ok = (msr_thread_in <= 8'(MAX_THREAD)) &&
                         thread_avail_in[msr_thread_in[3:0]];
  wire logic ser_busy;
  wire logic accept_cmd = msr_cmd_valid_in && !ser_busy &&
                          (state == PMSR_MSR_IDLE);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= PMSR_MSR_IDLE;
      msr_cc <= CC_PASS;
      msr_data <= 64'h0;
      msr_abort <= 1'b0;
      ser_load <= 1'b0;
      msr_lookup_out <= '0;
    end else begin
      ser_load <= 1'b0;
      msr_lookup_out.valid <= 1'b0;
      unique case (state)
        PMSR_MSR_IDLE: begin
          if (msr_cmd_valid_in && !ser_busy) begin
            msr_abort <= !frame_ok;
            msr_data <= 64'h0;
            if (!frame_ok) begin
              ser_load <= 1'b1;
            end else if (!thread_ok) begin
              msr_cc <= CC_ILLEGAL;
              ser_load <= 1'b1;
            end else begin
              // register picked by thread and address
              msr_lookup_out.valid <= 1'b1;
              msr_lookup_out.thread <= msr_thread_in[3:0];
              msr_lookup_out.addr <= msr_addr_in;
              state <= PMSR_MSR_LOOKUP;
            end
          end
        end
        PMSR_MSR_LOOKUP: begin
          if (msr_lookup_in.valid) begin
            // lookup reports 0x80..0x91 for timeout, power, unknown
            msr_cc <= msr_lookup_in.cc;
            msr_data <= (msr_lookup_in.cc == CC_PASS) ?
                        msr_lookup_in.data : 64'h0;
            ser_load <= 1'b1;
            state <= PMSR_MSR_SEND;
          end
        end
        PMSR_MSR_SEND: begin
          state <= PMSR_MSR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // answer serialiser: code plus eight data bytes
  // ----------------------------------------------------------------
  pmsr_byte_ser u_ser (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(ser_load),
    .cc_in(msr_cc),
    .data_in(msr_data),
    .nbytes_in(4'h8),
    .abort_in(msr_abort),
    .ready_in(rsp_ready_in),
    .byte_valid_out(rsp_byte_valid_out),
    .byte_out(rsp_byte_out),
    .last_out(rsp_last_out),
    .abort_out(rsp_abort_out),
    .busy_out(ser_busy)
  );

  // busy rises right after a take, so the host sees no idle gap
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      rsp_busy_out <= 1'b0;
    else
      rsp_busy_out <= ser_busy | ser_load | (state != PMSR_MSR_IDLE) |
                      accept_cmd;
  end
endmodule
`default_nettype wire

// *** shared/pmsr_pkg.sv ***
// package for the platform management service responder
// assumes one 100 MHz clock and a byte-wide frame port from the link layer
package pmsr_pkg;

  // ----------------------------------------------------------------
  // framing and service codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MSR_WRITE_LEN = 8'h05;
  localparam logic [7:0] MSR_READ_LEN = 8'h09;
  localparam logic [7:0] MSR_CMD_CODE = 8'hb1;
  localparam logic [7:0] CC_PASS = 8'h40;
  localparam logic [7:0] CC_TIMEOUT = 8'h80;
  localparam logic [7:0] CC_NO_RESOURCE = 8'h81;
  localparam logic [7:0] CC_LOW_POWER = 8'h82;
  localparam logic [7:0] CC_ILLEGAL = 8'h90;
  localparam logic [7:0] CC_INTERNAL = 8'h91;

  typedef enum logic [2:0] {
    PMSR_SVC_PERF_STATUS,
    PMSR_SVC_INDICATOR,
    PMSR_SVC_NOTIFY_WR,
    PMSR_SVC_NOTIFY_RD,
    PMSR_SVC_TABLE_RD,
    PMSR_SVC_MARGIN_RD
  } pmsr_svc_t;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TBL_BANK_LSB = 0;
  localparam int TBL_ENTRY_LSB = 2;
  localparam int TBL_AGENT_LSB = 7;
  localparam int TBL_MODE_BIT = 11;
  localparam int MARGIN_SIGN_BIT = 15;
  localparam int NOTIFY_MSB = 7;
  localparam int CORE_VALID_BIT = 8;
  localparam int NUM_AGENTS = 8;
  localparam int MAX_THREAD = 15;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CORE_VALID_US = 1000;
  localparam int CORE_VALID_CYC = CORE_VALID_US * CLK_MHZ;
  localparam logic [7:0] NOTIFY_RESET = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    pmsr_svc_t svc;
    logic [15:0] param;
    logic [31:0] wdata;
  } pmsr_svc_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] cc;
    logic [31:0] data;
  } pmsr_svc_rsp_t;

  typedef struct packed {
    logic valid;
    logic [3:0] thread;
    logic [15:0] addr;
  } pmsr_msr_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] cc;
    logic [63:0] data;
  } pmsr_msr_rsp_t;

endpackage

// *** rtl/pmsr_byte_ser.sv ***
// serialiser that sends a completion code then data bytes low first
// assumes the link layer takes one byte per cycle while ready is high
`timescale 1ns/10ps
`default_nettype none
module pmsr_byte_ser (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [7:0] cc_in,
  input wire logic [63:0] data_in,
  input wire logic [3:0] nbytes_in,
  input wire logic abort_in,
  input wire logic ready_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic last_out,
  output logic abort_out,
  output logic busy_out
);
  import pmsr_pkg::*;

  logic [71:0] shreg;
  logic [3:0] left;
  wire logic step;

  assign step = byte_valid_out & ready_in;

  // ----------------------------------------------------------------
  // shift out code first, then data low byte first
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      shreg <= 72'h0;
      left <= 4'h0;
      byte_valid_out <= 1'b0;
      byte_out <= 8'h00;
      last_out <= 1'b0;
      abort_out <= 1'b0;
      busy_out <= 1'b0;
    end else if (load_in && !busy_out) begin
      // abort sends no bytes, only the frame-check abort pulse
      abort_out <= abort_in;
      busy_out <= !abort_in;
      byte_valid_out <= !abort_in;
      byte_out <= cc_in; // code leads every answer
      shreg <= {8'h00, data_in};
      left <= nbytes_in;
      last_out <= (nbytes_in == 4'h0);
    end else begin
      abort_out <= 1'b0;
      if (step) begin
        byte_out <= shreg[7:0]; // low byte first
        shreg <= {8'h00, shreg[71:8]};
        if (left == 4'h0) begin
          byte_valid_out <= 1'b0;
          busy_out <= 1'b0;
          last_out <= 1'b0;
        end else begin
          left <= left - 4'h1;
          last_out <= (left == 4'h1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/pmsr_lookup_model.sv ***
// behavioural model of the core register lookup behind the responder
// assumes requests arrive as one-cycle pulses on the responder clock
`timescale 1ns/10ps
`default_nettype none
module pmsr_lookup_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pmsr_pkg::pmsr_msr_req_t req_in,
  input wire logic [3:0] delay_in,
  output pmsr_pkg::pmsr_msr_rsp_t rsp_out
);
  import pmsr_pkg::*;
  pmsr_msr_req_t held;
  logic [3:0] cnt;
  logic busy;
  // ------------------------------------------------------------
  // answer delay_in + 1 cycles after taking a request; idle payload toggles every cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    rsp_out.valid <= 1'b0;
    rsp_out.data <= ~rsp_out.data; // stale data must not look valid
    if (!rst_n_in) begin
      busy <= 1'b0;
      rsp_out.data <= '0;
    end else if (req_in.valid) begin
      busy <= 1'b1;
      cnt <= delay_in;
      held <= req_in;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      rsp_out.valid <= 1'b1;
      // address zero stands for an unimplemented register
      rsp_out.cc <= (held.addr == 16'h0) ? CC_ILLEGAL : CC_PASS;
      rsp_out.data <= (held.addr == 16'h0) ? 64'h0 :
        {4{held.addr ^ {12'h0, held.thread}}};
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/pmsr_checker_assertions.sv ***
// port-level assertions for the service responder
// assumes it is bound to pmsr_responder with one clock domain
`timescale 1ns/10ps
`default_nettype none
module pmsr_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pmsr_pkg::pmsr_svc_req_t svc_req_in,
  input wire pmsr_pkg::pmsr_svc_rsp_t svc_rsp_out,
  input wire logic msr_cmd_valid_in,
  input wire logic [7:0] msr_write_len_in,
  input wire logic [7:0] msr_read_len_in,
  input wire logic [7:0] msr_cmd_in,
  input wire logic [7:0] msr_thread_in,
  input wire logic [15:0] msr_addr_in,
  input wire pmsr_pkg::pmsr_msr_req_t msr_lookup_out,
  input wire logic [15:0] thread_avail_in,
  input wire logic rsp_ready_in,
  input wire logic rsp_byte_valid_out,
  input wire logic [7:0] rsp_byte_out,
  input wire logic rsp_last_out,
  input wire logic rsp_abort_out,
  input wire logic rsp_busy_out,
  input wire logic [15:0] margin_in,
  input wire logic [7:0] os_pstate_in,
  input wire logic [7:0] turbo_notify_threshold_out,
  input wire logic turbo_enable_out
);
  import pmsr_pkg::*;
  wire logic take;
  wire logic frame_ok;
  // ------------------------------------------------------------
  // command acceptance decode
  // ------------------------------------------------------------
  assign take = msr_cmd_valid_in && !rsp_busy_out;
  assign frame_ok = msr_write_len_in == MSR_WRITE_LEN &&
    msr_read_len_in == MSR_READ_LEN && msr_cmd_in == MSR_CMD_CODE;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  svc_answer_a: assert property (svc_req_in.valid |=> svc_rsp_out.valid)
    else $error("service request not answered next cycle");
  notify_echo_a: assert property (svc_req_in.valid &&
    svc_req_in.svc == PMSR_SVC_NOTIFY_RD |=>
    svc_rsp_out.data == {24'h0, turbo_notify_threshold_out})
    else $error("threshold read differs from stored value");
  margin_fmt_a: assert property (svc_req_in.valid &&
    svc_req_in.svc == PMSR_SVC_MARGIN_RD |=>
    svc_rsp_out.data == {16'h0, $past(margin_in)})
    else $error("margin answer wrong");
  frame_abort_a: assert property (take && !frame_ok |-> ##2 rsp_abort_out)
    else $error("bad frame not aborted");
  lookup_fwd_a: assert property (take && frame_ok &&
    msr_thread_in < 8'd16 && thread_avail_in[msr_thread_in[3:0]] |=>
    msr_lookup_out.valid && msr_lookup_out.addr == $past(msr_addr_in))
    else $error("lookup not issued for good command");
  bad_thread_a: assert property (take && frame_ok &&
    msr_thread_in > 8'd15 |=> !msr_lookup_out.valid ##1
    (rsp_byte_valid_out && rsp_byte_out == CC_ILLEGAL))
    else $error("out of range thread not refused");
  byte_hold_a: assert property (rsp_byte_valid_out && !rsp_ready_in
    |=> rsp_byte_valid_out && $stable(rsp_byte_out))
    else $error("answer byte dropped before taken");
  last_pair_a: assert property (rsp_last_out |-> rsp_byte_valid_out)
    else $error("last flag without byte");
  no_turbo_a: assert property ($past(os_pstate_in) <=
    turbo_notify_threshold_out |-> !turbo_enable_out)
    else $error("turbo at or below threshold");
endmodule
`default_nettype wire

// *** testbench/tb_pmsr_responder.sv ***
// self-checking bench for the service responder
// assumes the lookup model answers register reads
`timescale 1ns/10ps
`default_nettype none
module tb_pmsr_responder;
  import pmsr_pkg::*;
  typedef struct {
    logic [2:0] s; logic [15:0] p; logic [31:0] w;
    logic [7:0] cc; logic [31:0] d; logic m;
  } pmsr_row_t;
  pmsr_svc_req_t svc_req_in;
  pmsr_svc_rsp_t svc_rsp_out;
  pmsr_msr_req_t msr_lookup_out;
  pmsr_msr_rsp_t msr_lookup_in;
  logic clk_in, rst_n_in, msr_cmd_valid_in, rsp_ready_in;
  logic [7:0] msr_write_len_in, msr_read_len_in, msr_cmd_in, msr_thread_in;
  logic [15:0] msr_addr_in, thread_avail_in, margin_in;
  logic rsp_byte_valid_out, rsp_last_out, rsp_abort_out, rsp_busy_out;
  logic [7:0] rsp_byte_out, agent_enable_in, os_pstate_in, limit_pstate_in;
  logic pkg_clamped_in, core_retiring_in, internal_error_flag_in;
  logic [3:0] first_failing_core_in, energy_perf_bias_in, lm_delay;
  logic [31:0] table_data_in;
  logic [10:0] table_sel_out;
  logic [7:0] turbo_max_in, granted_pstate_out, turbo_notify_threshold_out;
  logic turbo_enable_out;
  logic [23:0] good;
  int mismatches, n_compared;
  pmsr_row_t rows[7] = '{
    '{3'd2, 16'h0, 32'h25, CC_PASS, 32'h0, 1'b0},
    '{3'd3, 16'h0, 32'h0, CC_PASS, 32'h25, 1'b1},
    '{3'd5, 16'h0, 32'h0, CC_PASS, 32'h8a45, 1'b1},
    '{3'd4, 16'h01ce, 32'h0, CC_PASS, 32'h1234_5678, 1'b1},
    '{3'd4, 16'h0280, 32'h0, CC_PASS, 32'h0, 1'b1},
    '{3'd6, 16'h0, 32'h0, CC_ILLEGAL, 32'h0, 1'b1},
    '{3'd7, 16'h0, 32'h0, CC_ILLEGAL, 32'h0, 1'b1}};
  pmsr_responder u_dut (.clk_in, .rst_n_in, .svc_req_in, .svc_rsp_out,
    .msr_cmd_valid_in, .msr_write_len_in, .msr_read_len_in, .msr_cmd_in,
    .msr_thread_in, .msr_addr_in, .msr_lookup_out, .msr_lookup_in,
    .thread_avail_in, .rsp_ready_in, .rsp_byte_valid_out, .rsp_byte_out,
    .rsp_last_out, .rsp_abort_out, .rsp_busy_out, .pkg_clamped_in,
    .core_retiring_in, .internal_error_flag_in, .first_failing_core_in,
    .agent_enable_in, .margin_in, .table_data_in, .table_sel_out,
    .os_pstate_in, .limit_pstate_in, .energy_perf_bias_in, .turbo_max_in,
    .granted_pstate_out, .turbo_enable_out, .turbo_notify_threshold_out);
  pmsr_lookup_model u_lm (.clk_in, .rst_n_in, .req_in(msr_lookup_out),
    .delay_in(lm_delay), .rsp_out(msr_lookup_in));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic svc(input logic [2:0] s, input logic [15:0] p,
                     input logic [31:0] w);
    @(posedge clk_in);
    svc_req_in <= '{1'b1, pmsr_svc_t'(s), p, w};
    @(posedge clk_in);
    svc_req_in.valid <= 1'b0;
    @(negedge clk_in);
    chk(svc_rsp_out.valid, 1'b1);
  endtask
  // waits for idle first, since a busy responder ignores commands
  task automatic msr(input logic [23:0] f, input logic [7:0] t,
                     input logic [15:0] a);
    for (int k = 0; k < 50; k++) begin
      @(negedge clk_in);
      if (rsp_busy_out === 1'b0) break;
    end
    @(posedge clk_in);
    {msr_write_len_in, msr_read_len_in, msr_cmd_in} <= f;
    msr_thread_in <= t;
    msr_addr_in <= a;
    msr_cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    msr_cmd_valid_in <= 1'b0;
  endtask
  task automatic rx(input logic [7:0] cc, input logic [63:0] d);
    logic [71:0] e;
    int i;
    e = {d, cc};
    i = 0;
    for (int k = 0; k < 200 && i < 9; k++) begin
      @(negedge clk_in);
      if (rsp_byte_valid_out === 1'b1 && rsp_ready_in === 1'b1) begin
        chk(rsp_byte_out, e[8*i +: 8]);
        chk(rsp_last_out, i == 8);
        i++;
      end
    end
    chk(i, 9);
  endtask
  // ------------------------------------------------------------
  // clock, link stall pattern, watchdog
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // link takes a byte only every other cycle to exercise holding
  always @(posedge clk_in) rsp_ready_in <= ~rsp_ready_in;
  initial begin
    #1200000;
    mismatches++;
    conclude();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    good = {MSR_WRITE_LEN, MSR_READ_LEN, MSR_CMD_CODE};
    {rst_n_in, svc_req_in, msr_cmd_valid_in, rsp_ready_in} = '0;
    {msr_write_len_in, msr_read_len_in, msr_cmd_in, msr_thread_in} = '0;
    {msr_addr_in, pkg_clamped_in, core_retiring_in, lm_delay} = '0;
    {internal_error_flag_in, first_failing_core_in} = '0;
    {os_pstate_in, limit_pstate_in, energy_perf_bias_in} = '0;
    thread_avail_in = 16'h800f;
    agent_enable_in = 8'h0f;
    margin_in = 16'h8a45;
    table_data_in = 32'h1234_5678;
    turbo_max_in = 8'h40;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    chk({rsp_busy_out, turbo_enable_out, turbo_notify_threshold_out}, 0);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      svc(rows[i].s, rows[i].p, rows[i].w);
      chk(svc_rsp_out.cc, rows[i].cc);
      if (rows[i].m) chk(svc_rsp_out.data, rows[i].d);
      if (rows[i].s == 3'd4) chk(table_sel_out, rows[i].p[10:0]);
    end
    // counters: clamped 50 cycles, retiring 70 cycles
    @(posedge clk_in);
    {pkg_clamped_in, core_retiring_in} <= 2'b11;
    repeat (50) @(posedge clk_in);
    pkg_clamped_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    core_retiring_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    svc(3'd0, 16'h0, 32'h0);
    chk(svc_rsp_out.data, 32'd50);
    svc(3'd1, 16'h0, 32'h0);
    chk(svc_rsp_out.data, 32'd70);
    // performance grant against threshold 0x25
    for (int b = 0; b < 6; b++) begin
      @(posedge clk_in);
      os_pstate_in <= (b < 2) ? 8'h20 : 8'h30;
      limit_pstate_in <= (b == 1) ? 8'h30 : 8'h10;
      energy_perf_bias_in <= 4'(b * 3);
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk(turbo_enable_out, b > 1);
      if (b < 2) chk(granted_pstate_out, (b == 1) ? 8'h20 : 8'h10);
      else chk(granted_pstate_out, 8'(8'h10 + ((48 * (15 - b * 3)) >> 4)));
    end
    // register reads: good, slow, refused thread, unknown register
    msr(good, 8'h03, 16'h0401);
    rx(CC_PASS, {4{16'h0401 ^ 16'h0003}});
    lm_delay <= 4'h9;
    msr(good, 8'h0f, 16'h043e);
    rx(CC_PASS, {4{16'h043e ^ 16'h000f}});
    msr(good, 8'h05, 16'h0401);
    rx(CC_ILLEGAL, 64'h0);
    msr(good, 8'h10, 16'h0401);
    rx(CC_ILLEGAL, 64'h0);
    msr(good, 8'h03, 16'h0000);
    rx(CC_ILLEGAL, 64'h0);
    for (int j = 0; j < 3; j++) begin
      msr(good ^ (24'h1 << (8 * j)), 8'h03, 16'h0401);
      repeat (2) @(negedge clk_in);
      chk({rsp_abort_out, rsp_byte_valid_out}, 2'b10);
    end
    // first failing core is only trusted after the settle time
    @(posedge clk_in);
    internal_error_flag_in <= 1'b1;
    first_failing_core_in <= 4'h9;
    repeat (5) @(posedge clk_in);
    svc(3'd4, 16'h0800, 32'h0);
    chk(svc_rsp_out.data[CORE_VALID_BIT], 1'b0);
    repeat (CORE_VALID_CYC) @(posedge clk_in);
    svc(3'd4, 16'h0fff, 32'h0);
    chk(svc_rsp_out.data, 32'h0000_0109);
    conclude();
  end
endmodule
bind pmsr_responder pmsr_checker u_chk (.clk_in, .rst_n_in, .svc_req_in,
  .svc_rsp_out, .msr_cmd_valid_in, .msr_write_len_in, .msr_read_len_in,
  .msr_cmd_in, .msr_thread_in, .msr_addr_in, .msr_lookup_out,
  .thread_avail_in, .rsp_ready_in, .rsp_byte_valid_out, .rsp_byte_out,
  .rsp_last_out, .rsp_abort_out, .rsp_busy_out, .margin_in, .os_pstate_in,
  .turbo_notify_threshold_out, .turbo_enable_out);
`default_nettype wire
